/* File: logic/wdg_top.sv */
// file: watchdog top with apb registers, mode gating and reset pulse generation
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Operation
// - 6-bit counter after shared 12-bit prescaler
// - overflow forces reset at selected count
// - write to clear address restarts period
// - reset holds pin low, sets cause
// - monitor or break with test voltage disables
// - stop clears prescaler, halts oscillator clock
// - clear address reads reset vector low
// - power-on clears prescaler after 4096 cycles
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - rate bit picks short or long timeout
// - disable bit turns watchdog off
// - never raises an interrupt request
// - blank-vector monitor entry disables until power-on
// - keeps counting during wait mode
// - disabled stop gives illegal opcode reset
module wdg_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system mode inputs
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic rst_pin_test_voltage,
   input wire logic first_interrupt_pin_test_voltage,
   input wire logic monitor_blank_vectors,
   input wire logic power_on,
   input wire logic internal_reset,
   input wire logic [7:0] reset_vector_low,
   // reset outputs
   output logic rst_pin_low,
   output logic illegal_opcode_reset,
   output logic watchdog_reset
);
   logic [7:0] config_one;
   logic [4:0] reset_cause_status;
   logic stopped;
   logic blank_lock;
   logic [12:0] por_count;
   logic por_done;
   logic [5:0] hold_count;
   logic [1:0] div_count;
   logic osc_en;
   wdg_pkg::wdg_state_t state;
   wdg_pkg::wdg_state_t next_state;
   wdg_ctl_if ctl ();

   // address decode
   logic acc;
   logic wr;
   logic rd;
   logic hit_clear;
   logic hit_cfg;
   logic hit_stat;
   logic hit_ctl;
   logic hit_vec;
   logic mapped;
   logic stop_req;
   logic wait_req;
   logic vfetch;
   logic test_disable;
   logic enabled;
   logic [31:0] next_rdata;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign hit_clear = paddr == wdg_pkg::ADDR_WATCHDOG_CLEAR;
   assign hit_cfg = paddr == wdg_pkg::ADDR_CONFIG_ONE;
   assign hit_stat = paddr == wdg_pkg::ADDR_STATUS;
   assign hit_ctl = paddr == wdg_pkg::ADDR_CONTROL;
   assign hit_vec = paddr == wdg_pkg::ADDR_VECTOR;
   assign mapped = hit_clear | hit_cfg | hit_stat | hit_ctl | hit_vec;
   assign stop_req = wr && hit_ctl && pwdata[wdg_pkg::CTL_STOP_BIT];
   // wait only releases a held stop: the prescaler keeps running on its own
   assign wait_req = wr && hit_ctl && pwdata[wdg_pkg::CTL_WAIT_BIT];
   assign vfetch = (wr && hit_ctl && pwdata[wdg_pkg::CTL_VFETCH_BIT]) ||
      (rd && hit_vec);
   // break only honours the reset pin, monitor honours either pin
   assign test_disable = (monitor_mode &&
      (rst_pin_test_voltage || first_interrupt_pin_test_voltage)) ||
      (break_state && rst_pin_test_voltage);
   assign enabled = !config_one[wdg_pkg::CFG_DISABLE_BIT] && !test_disable &&
      !blank_lock && state == wdg_pkg::WDG_RUN;
   assign por_done = por_count == 13'(wdg_pkg::POR_CYCLES);

   // control bundle to the core; stop freezes the oscillator tick
   assign ctl.osc_tick = osc_en && !stopped;
   assign ctl.run = enabled;
   assign ctl.rate_fast = config_one[wdg_pkg::CFG_RATE_BIT];
   assign ctl.clr_counter = internal_reset || (wr && hit_clear);
   assign ctl.clr_prescale = internal_reset || vfetch ||
      (stop_req && !config_one[wdg_pkg::CFG_STOP_DIS_BIT]) ||
      (osc_en && por_count == 13'(wdg_pkg::POR_CYCLES - 1));
   assign ctl.clr_prescale_hi = wr && hit_clear;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_clear) begin
         next_rdata[7:0] = reset_vector_low;
      end else if (hit_cfg) begin
         next_rdata[7:0] = config_one;
      end else if (hit_stat) begin
         next_rdata[4:0] = reset_cause_status;
         next_rdata[wdg_pkg::STAT_STOPPED_BIT] = stopped;
      end else if (hit_vec) begin
         next_rdata[7:0] = reset_vector_low;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         wdg_pkg::WDG_RUN: begin
            if (ctl.expire) begin
               next_state = wdg_pkg::WDG_HOLD;
            end
         end
         wdg_pkg::WDG_HOLD: begin
            if (osc_en && hold_count == 6'(wdg_pkg::RESET_HOLD_CYCLES - 1)) begin
               next_state = wdg_pkg::WDG_RUN;
            end
         end
         default: next_state = wdg_pkg::WDG_RUN;
      endcase
   end

   wdg_core u_core (
      .pclk(pclk),
      .presetn(presetn),
      .ctl(ctl)
   );

   // oscillator enable divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= '0;
         osc_en <= 1'b0;
      end else begin
         div_count <= div_count + 2'd1;
         osc_en <= div_count == 2'(wdg_pkg::OSC_DIV - 1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_count <= '0;
      end else if (power_on) begin
         por_count <= '0;
      end else if (osc_en && !por_done) begin
         por_count <= por_count + 13'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_one <= wdg_pkg::CONFIG_ONE_RESET;
      end else if (internal_reset) begin
         config_one[wdg_pkg::CFG_RATE_BIT] <= 1'b0;
      end else if (wr && hit_cfg) begin
         config_one <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_lock <= 1'b0;
      end else if (power_on) begin
         blank_lock <= 1'b0;
      end else if (monitor_mode && monitor_blank_vectors &&
         !first_interrupt_pin_test_voltage) begin
         blank_lock <= 1'b1;
      end
   end

   // stop holds until wait or a reset; stop-disabled stop is illegal opcode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopped <= 1'b0;
         illegal_opcode_reset <= 1'b0;
      end else begin
         illegal_opcode_reset <= stop_req && config_one[wdg_pkg::CFG_STOP_DIS_BIT];
         if (internal_reset || wait_req) begin
            stopped <= 1'b0;
         end else if (stop_req && !config_one[wdg_pkg::CFG_STOP_DIS_BIT]) begin
            stopped <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= wdg_pkg::WDG_RUN;
         hold_count <= '0;
         rst_pin_low <= 1'b0;
         watchdog_reset <= 1'b0;
      end else begin
         state <= next_state;
         if (state == wdg_pkg::WDG_RUN) begin
            hold_count <= '0;
         end else if (osc_en) begin
            hold_count <= hold_count + 6'd1;
         end
         rst_pin_low <= next_state == wdg_pkg::WDG_HOLD;
         watchdog_reset <= ctl.expire;
      end
   end

   // cause flags: a new event wins over a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_cause_status <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (wr && hit_stat && pwdata[i]) begin
               reset_cause_status[i] <= 1'b0;
            end
         end
         if (ctl.expire) begin
            reset_cause_status[wdg_pkg::STAT_WDG_CAUSE_BIT] <= 1'b1;
         end
         if (stop_req && config_one[wdg_pkg::CFG_STOP_DIS_BIT]) begin
            reset_cause_status[wdg_pkg::STAT_ILLOP_CAUSE_BIT] <= 1'b1;
         end
         if (power_on) begin
            reset_cause_status[wdg_pkg::STAT_POR_BIT] <= 1'b1;
         end
      end
   end

   // apb: zero wait states; no interrupt output exists at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctl.expire |=> rst_pin_low && reset_cause_status[wdg_pkg::STAT_WDG_CAUSE_BIT])
      else $error("expiry did not pull pin");
   test_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      test_disable |-> !ctl.run)
      else $error("watchdog ran under test voltage");
   stop_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      stop_req && !config_one[wdg_pkg::CFG_STOP_DIS_BIT] |=> ctl.prescale == 12'h000 && stopped)
      else $error("stop did not clear prescaler");
   read_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_clear |=> prdata == {24'h0, $past(reset_vector_low)})
      else $error("clear address read wrong");
   irst_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      internal_reset |=> ctl.prescale == 12'h000 && ctl.count == 6'h00)
      else $error("internal reset left state");
   vfetch_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      vfetch |=> ctl.prescale == 12'h000)
      else $error("vector fetch left prescaler");
   disable_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      config_one[wdg_pkg::CFG_DISABLE_BIT] |-> !ctl.run)
      else $error("disabled watchdog ran");
   blank_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      blank_lock && !power_on |=> blank_lock && !ctl.run)
      else $error("blank lock released");
   illop_a: assert property (@(posedge pclk) disable iff (!presetn)
      stop_req && config_one[wdg_pkg::CFG_STOP_DIS_BIT] |=> illegal_opcode_reset && !stopped)
      else $error("stop not refused");

   // expiry: one pulse while the pin goes low, then the pin stays low alone
   sequence reset_pulse_s;
      watchdog_reset && rst_pin_low;
   endsequence
   expiry_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctl.expire |=> reset_pulse_s ##1 (!watchdog_reset && rst_pin_low))
      else $error("expiry pulse malformed");
   // a short hold would let the far side leave reset before it settles
   pin_release_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(rst_pin_low) |->
      $past(hold_count) == 6'(wdg_pkg::RESET_HOLD_CYCLES - 1) && $past(osc_en))
      else $error("pin hold ended early");
   stop_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      stopped && !ctl.clr_prescale && !ctl.clr_prescale_hi |=> $stable(ctl.prescale))
      else $error("prescaler ran while stopped");
   rate_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      internal_reset |=> !config_one[wdg_pkg::CFG_RATE_BIT])
      else $error("reset kept rate bit");
   wait_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
      wait_req |=> !stopped)
      else $error("wait left clock stopped");
endmodule

/* File: logic/wdg_pkg.sv */
// package: watchdog register map, field positions, reset values and timing counts
package wdg_pkg;
   // watchdog_clear keeps its location as a word index; the bus sees four times it
   localparam logic [15:0] IDX_WATCHDOG_CLEAR = 16'hffff;
   localparam logic [17:0] ADDR_WATCHDOG_CLEAR = {IDX_WATCHDOG_CLEAR, 2'b00};
   localparam logic [17:0] ADDR_CONFIG_ONE = 18'h0_0000;
   localparam logic [17:0] ADDR_STATUS = 18'h0_0004;
   localparam logic [17:0] ADDR_CONTROL = 18'h0_0008;
   localparam logic [17:0] ADDR_VECTOR = 18'h0_000c;
   // config_one fields
   localparam int CFG_RATE_BIT = 0;
   localparam int CFG_DISABLE_BIT = 1;
   localparam int CFG_STOP_DIS_BIT = 2;
   localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
   // status fields
   localparam int STAT_WDG_CAUSE_BIT = 0;
   localparam int STAT_ILLOP_CAUSE_BIT = 1;
   localparam int STAT_POR_BIT = 2;
   localparam int STAT_RST_PIN_BIT = 3;
   localparam int STAT_STOPPED_BIT = 4;
   // control fields (write one pulses)
   localparam int CTL_STOP_BIT = 0;
   localparam int CTL_WAIT_BIT = 1;
   localparam int CTL_VFETCH_BIT = 2;
   // reset vector low byte default
   localparam logic [7:0] VECTOR_LOW_RESET = 8'h00;
   // widths
   localparam int PRESCALE_W = 12;
   localparam int WDG_W = 6;
   // fast rate: counter overflow taps prescaler stage 7, slow rate: stage 12
   localparam int FAST_TAP = 7;
   localparam int SLOW_TAP = 12;
   // cleared prescaler stages 12..5 (bits 11..4 of the 12-bit value)
   localparam logic [11:0] PRESCALE_CLEAR_MASK = 12'h00f;
   localparam int POR_CYCLES = 4096;
   localparam int RESET_HOLD_CYCLES = 32;
   // osc clock as a fraction of pclk: one enable per this many pclk cycles
   localparam int OSC_DIV = 4;
   typedef enum logic [1:0] {
      WDG_RUN,
      WDG_HOLD
   } wdg_state_t;
endpackage

/* File: logic/wdg_ctl_if.sv */
// interface: control signals passed from the top into the watchdog counter core
`timescale 1ns/1ps
interface wdg_ctl_if;
   logic osc_tick;
   logic clr_counter;
   logic clr_prescale;
   logic clr_prescale_hi;
   logic run;
   logic rate_fast;
   logic expire;
   logic [11:0] prescale;
   logic [5:0] count;
   modport top (output osc_tick, clr_counter, clr_prescale, clr_prescale_hi, run, rate_fast,
      input expire, prescale, count);
   modport core (input osc_tick, clr_counter, clr_prescale, clr_prescale_hi, run, rate_fast,
      output expire, prescale, count);
endinterface

/* File: logic/wdg_core.sv */
// file: prescaler plus 6-bit watchdog counter with overflow pulse
`timescale 1ns/1ps
module wdg_core (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   wdg_ctl_if.core ctl
);
   logic [11:0] prescale;
   logic [5:0] count;
   logic [12:0] next_pre;
   logic tap_carry;
   logic [6:0] next_cnt;
   logic expire;

   // prescale+1 carries in bit 12; tap picks which stage drives the counter
   assign next_pre = {1'b0, prescale} + 13'h0001;
   assign tap_carry = ctl.rate_fast ?
      (prescale[wdg_pkg::FAST_TAP-1:0] == {wdg_pkg::FAST_TAP{1'b1}}) : next_pre[12];
   assign next_cnt = {1'b0, count} + 7'h01;
   assign ctl.prescale = prescale;
   assign ctl.count = count;
   assign ctl.expire = expire;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= '0;
      end else if (ctl.clr_prescale) begin
         prescale <= '0;
      end else if (ctl.clr_prescale_hi) begin
         prescale <= prescale & wdg_pkg::PRESCALE_CLEAR_MASK;
      end else if (ctl.osc_tick) begin
         prescale <= next_pre[11:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (ctl.clr_counter) begin
            count <= '0;
         end else if (ctl.osc_tick && ctl.run && tap_carry) begin
            count <= next_cnt[5:0];
            expire <= next_cnt[6];
         end
      end
   end

   expire_after_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctl.osc_tick && ctl.run && tap_carry && count == 6'h3f && !ctl.clr_counter |=> expire)
      else $error("overflow did not expire");
   clear_zeroes_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctl.clr_counter |=> count == 6'h00)
      else $error("counter not cleared");
endmodule

/* File: verification/wdg_sys_model.sv */
// partner model: system reset logic that turns the block's reset pulses into internal reset
`timescale 1ns/1ps
module wdg_sys_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // reset requests from the block
   input wire logic watchdog_reset,
   input wire logic illegal_opcode_reset,
   // power-up request from the bench
   input wire logic por_req,
   // towards the block
   output logic power_on,
   output logic internal_reset
);
   logic [1:0] hold;
   logic req;
   assign req = watchdog_reset || illegal_opcode_reset;
   // internal reset stretched to three cycles, as slow system logic would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= 2'h0;
         internal_reset <= 1'b0;
         power_on <= 1'b0;
      end else begin
         hold <= req ? 2'h2 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
         internal_reset <= req || (hold != 2'h0);
         power_on <= por_req;
      end
   end
endmodule

/* File: verification/testbench.sv */
// self-checking bench: register table, stop handling, gating and timeout measurement
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic w;
      logic [17:0] a;
      logic [31:0] d;
      logic [31:0] m;
      logic [31:0] e;
      logic err;
   } wdg_row_t;
   localparam logic [7:0] VEC = 8'ha5;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h0_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic monitor_mode = 1'b0;
   logic break_state = 1'b0;
   logic rst_tv = 1'b0;
   logic irq_tv = 1'b0;
   logic blank_vec = 1'b0;
   logic por_req = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic power_on;
   logic internal_reset;
   logic rst_pin_low;
   logic illegal_opcode_reset;
   logic watchdog_reset;
   logic [31:0] rd;
   logic er;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_wdg = 0;
   int n_ill = 0;
   int run = 0;
   int pin_run = 0;
   int wdg_cyc = 0;

   wdg_top wdg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .monitor_mode(monitor_mode), .break_state(break_state),
      .rst_pin_test_voltage(rst_tv), .first_interrupt_pin_test_voltage(irq_tv),
      .monitor_blank_vectors(blank_vec), .power_on(power_on), .internal_reset(internal_reset),
      .reset_vector_low(VEC), .rst_pin_low(rst_pin_low),
      .illegal_opcode_reset(illegal_opcode_reset), .watchdog_reset(watchdog_reset));
   wdg_sys_model wdg_sys_model_inst (.pclk(pclk), .presetn(presetn),
      .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
      .por_req(por_req), .power_on(power_on), .internal_reset(internal_reset));

   always #2 pclk = ~pclk;

   // event counters, so that short pulses are never missed between bus cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (watchdog_reset === 1'b1) begin
         n_wdg <= n_wdg + 1;
         wdg_cyc <= cyc;
      end
      if (illegal_opcode_reset === 1'b1)
         n_ill <= n_ill + 1;
      run <= (rst_pin_low === 1'b1) ? run + 1 : 0;
      if (rst_pin_low !== 1'b1 && run != 0)
         pin_run <= run;
   end

   task automatic report_and_stop();
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_in(input int v, input int lo, input int hi);
      n_compared++;
      if (v < lo || v > hi) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h to %h", $time, v, lo, hi);
      end
   endtask

   task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         fails++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      wdg_row_t rows [9];
      int t0;
      int k;
      rows = '{
         '{1'b0, wdg_pkg::ADDR_CONFIG_ONE, 32'h0, 32'hff, {24'h0, wdg_pkg::CONFIG_ONE_RESET}, 1'b0},
         '{1'b0, wdg_pkg::ADDR_WATCHDOG_CLEAR, 32'h0, 32'hff, {24'h0, VEC}, 1'b0},
         '{1'b1, wdg_pkg::ADDR_WATCHDOG_CLEAR, 32'h5a, 32'h0, 32'h0, 1'b0},
         '{1'b0, wdg_pkg::ADDR_VECTOR, 32'h0, 32'hff, {24'h0, VEC}, 1'b0},
         '{1'b1, wdg_pkg::ADDR_CONTROL, 32'h04, 32'h0, 32'h0, 1'b0},
         '{1'b0, 18'h0_0010, 32'h0, 32'h0, 32'h0, 1'b1},
         '{1'b1, wdg_pkg::ADDR_CONFIG_ONE, 32'h04, 32'h0, 32'h0, 1'b0},
         '{1'b0, wdg_pkg::ADDR_CONFIG_ONE, 32'h0, 32'h07, 32'h04, 1'b0},
         '{1'b0, wdg_pkg::ADDR_STATUS, 32'h0, 32'h03, 32'h0, 1'b0}};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      por_req <= 1'b1;
      @(posedge pclk);
      por_req <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(rd & rows[i].m, rows[i].e);
         chk({31'h0000_0000, er}, {31'h0000_0000, rows[i].err});
      end
      // stop while the stop instruction is disabled
      apb(1'b1, wdg_pkg::ADDR_CONTROL, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      chk(n_ill, 1);
      apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0012, 32'h0000_0002);
      apb(1'b1, wdg_pkg::ADDR_CONFIG_ONE, 32'h0000_0001);
      apb(1'b1, wdg_pkg::ADDR_CONTROL, 32'h0000_0001);
      apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0010, 32'h0000_0010);
      apb(1'b1, wdg_pkg::ADDR_CONTROL, 32'h0000_0002);
      apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0010, 32'h0000_0000);
      apb(1'b1, wdg_pkg::ADDR_STATUS, 32'h0000_0003);
      apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0003, 32'h0000_0000);
      // five gated spans; any one that fails to gate pushes the total past a fast timeout
      apb(1'b1, wdg_pkg::ADDR_WATCHDOG_CLEAR, 32'h0000_00c3);
      for (int g = 0; g < 5; g++) begin
         monitor_mode <= (g < 2) || (g == 4);
         break_state <= (g == 2);
         irq_tv <= (g == 0);
         rst_tv <= (g == 1 || g == 2);
         blank_vec <= (g == 4);
         if (g == 3)
            apb(1'b1, wdg_pkg::ADDR_CONFIG_ONE, 32'h0000_0003);
         if (g == 4)
            apb(1'b1, wdg_pkg::ADDR_CONFIG_ONE, 32'h0000_0001);
         repeat (7000) @(posedge pclk);
      end
      // only a power-on lifts the blank-vector lock
      monitor_mode <= 1'b0;
      blank_vec <= 1'b0;
      @(posedge pclk);
      por_req <= 1'b1;
      @(posedge pclk);
      por_req <= 1'b0;
      repeat (27000) @(posedge pclk);
      chk(n_wdg, 0);
      apb(1'b1, wdg_pkg::ADDR_WATCHDOG_CLEAR, 32'h0000_003c);
      t0 = cyc;
      for (k = 0; k < 34000 && n_wdg == 0; k++)
         @(posedge pclk);
      if (n_wdg == 0) begin
         fails++;
         report_and_stop();
      end
      chk_in(wdg_cyc - t0, 32620, 32800);
      for (k = 0; k < 300 && pin_run == 0; k++)
         @(posedge pclk);
      chk_in(pin_run, 124, 132);
      apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      apb(1'b0, wdg_pkg::ADDR_CONFIG_ONE, 32'h0000_0000);
      chk(rd & 32'h0000_0001, 32'h0000_0000);
      chk(n_wdg, 1);
      report_and_stop();
   end
endmodule
